// file: hw/interrupt_priority_unit.sv
// Interrupt priority unit: gathers peripheral requests into one CPU request
//
// Overview of operation
// - Peripheral requests in; request, level, vector out
// - Each source has one of eight levels
// - Highest configured level wins
// - Level tie goes to smallest vector
// - Handler address is base plus four times vector
// - Vector zero is reset, top priority
// - Fixed vectors 4,5,7,9,11 for named sources
// - Serial channel causes share vector 10
// - I2C channel causes share vector 13
// - Vectors 3,6,8,21 are never issued
// - Table base resets to 0x8000
// - Clock source from either oscillator stabilization
// - Level zero requests are never taken
// - Higher cause replaces pending; cleared flag cancels
// - Request whenever flag and enable both set and the source level is nonzero
// - Watchdog overflow goes to reset or NMI
`timescale 1ns/1ns
module interrupt_priority_unit (
    // Clock and reset
    input  wire logic                                   i_clk,
    input  wire logic                                   i_rst,
    // Reset causes
    input  wire logic                                   i_reset_cause,
    input  wire logic                                   i_watchdog_overflow,
    input  wire logic                                   i_watchdog_to_nmi,
    // Peripheral flags and enables
    input  wire logic                                   i_supply_flag,
    input  wire logic                                   i_supply_en,
    input  wire logic                                   i_port_flag,
    input  wire logic                                   i_port_en,
    input  wire logic [1:0]                             i_clock_gen_flag,
    input  wire logic [1:0]                             i_clock_gen_en,
    input  wire logic                                   i_timer0_flag,
    input  wire logic                                   i_timer0_en,
    input  wire logic [vip_pkg::SERIAL_CAUSES-1:0]      i_serial0_flag,
    input  wire logic [vip_pkg::SERIAL_CAUSES-1:0]      i_serial0_en,
    input  wire logic                                   i_timer1_flag,
    input  wire logic                                   i_timer1_en,
    input  wire logic [vip_pkg::I2C_CAUSES-1:0]         i_i2c0_flag,
    input  wire logic [vip_pkg::I2C_CAUSES-1:0]         i_i2c0_en,
    // Level configuration, one 3-bit field per maskable source
    input  wire logic [vip_pkg::NUM_SRC*vip_pkg::LVL_W-1:0] i_level,
    input  wire logic                                   i_level_we,
    // Table base write
    input  wire logic [23:0]                            i_table_base_wdata,
    input  wire logic                                   i_table_base_we,
    // CPU side
    input  wire logic                                   i_cpu_ack,
    output logic                                        o_cpu_req,
    output logic                                        o_cpu_nmi,
    output logic                                        o_cpu_reset,
    output logic [vip_pkg::LVL_W-1:0]                   o_cpu_level,
    output logic [vip_pkg::VEC_W-1:0]                   o_cpu_vector,
    output logic [23:0]                                 o_vector_address,
    output logic [23:0]                                 o_table_base
);
    localparam int N = vip_pkg::NUM_SRC;
    localparam int NBASE = 24 - vip_pkg::BASE_ALIGN_BITS;

    logic [N-1:0]                       src_req;
    logic [N*vip_pkg::VEC_W-1:0]        src_vec;
    logic [N*vip_pkg::LVL_W-1:0]        level;
    logic [N*vip_pkg::LVL_W-1:0]        next_level;
    logic [NBASE-1:0]                   base_hi;
    logic [NBASE-1:0]                   next_base_hi;
    logic                               req;
    logic                               next_req;
    logic [vip_pkg::LVL_W-1:0]          lvl_q;
    logic [vip_pkg::LVL_W-1:0]          next_lvl_q;
    logic [vip_pkg::VEC_W-1:0]          vec_q;
    logic [vip_pkg::VEC_W-1:0]          next_vec_q;
    logic                               nmi;
    logic                               next_nmi;
    logic                               rst_req;
    logic                               next_rst_req;
    logic [2:0]                         cause_sync;
    logic [2:0]                         next_cause_sync;
    logic                               cause_seen;
    logic                               next_cause_seen;

    vip_req_if win ();

    vip_cause_gate #(.N(1)) u_supply (
        .i_flag   (i_supply_flag),
        .i_enable (i_supply_en),
        .o_req    (src_req[0])
    );
    vip_cause_gate #(.N(1)) u_port (
        .i_flag   (i_port_flag),
        .i_enable (i_port_en),
        .o_req    (src_req[1])
    );
    vip_cause_gate #(.N(2)) u_clock_gen (
        .i_flag   (i_clock_gen_flag),
        .i_enable (i_clock_gen_en),
        .o_req    (src_req[2])
    );
    vip_cause_gate #(.N(1)) u_timer0 (
        .i_flag   (i_timer0_flag),
        .i_enable (i_timer0_en),
        .o_req    (src_req[3])
    );
    vip_cause_gate #(.N(vip_pkg::SERIAL_CAUSES)) u_serial0 (
        .i_flag   (i_serial0_flag),
        .i_enable (i_serial0_en),
        .o_req    (src_req[4])
    );
    vip_cause_gate #(.N(1)) u_timer1 (
        .i_flag   (i_timer1_flag),
        .i_enable (i_timer1_en),
        .o_req    (src_req[5])
    );
    vip_cause_gate #(.N(vip_pkg::I2C_CAUSES)) u_i2c0 (
        .i_flag   (i_i2c0_flag),
        .i_enable (i_i2c0_en),
        .o_req    (src_req[6])
    );

    assign src_vec = {vip_pkg::VEC_I2C0,     vip_pkg::VEC_TIMER1,
                      vip_pkg::VEC_SERIAL0,  vip_pkg::VEC_TIMER0,
                      vip_pkg::VEC_CLOCK_GEN, vip_pkg::VEC_PORT,
                      vip_pkg::VEC_SUPPLY};

    vip_resolver #(.N(N)) u_resolver (
        .i_req    (src_req),
        .i_level  (level),
        .i_vector (src_vec),
        .win      (win.src)
    );

    // Configuration state
    always_comb begin
        next_level   = level;
        next_base_hi = base_hi;
        if (i_level_we) begin
            next_level = i_level;
        end
        // Low byte is fixed so the table stays on a 256-byte boundary
        if (i_table_base_we) begin
            next_base_hi = i_table_base_wdata[23:vip_pkg::BASE_ALIGN_BITS];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            level   <= {N{vip_pkg::LVL_RESET}};
            base_hi <= vip_pkg::TABLE_BASE_INIT[23:vip_pkg::BASE_ALIGN_BITS];
        end else begin
            level   <= next_level;
            base_hi <= next_base_hi;
        end
    end

    // Reset causes come from pins and detectors outside this clock: three
    // stages, and a change counts only once the last two agree.
    // A one-cycle glitch never reaches both, so it is ignored.
    always_comb begin
        next_cause_sync = {cause_sync[1:0], i_reset_cause};
        next_cause_seen = cause_seen;
        if (cause_sync[1] == cause_sync[2]) begin
            next_cause_seen = cause_sync[2];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cause_sync <= '0;
            cause_seen <= 1'b0;
        end else begin
            cause_sync <= next_cause_sync;
            cause_seen <= next_cause_seen;
        end
    end

    // Request state toward the CPU
    always_comb begin
        next_req     = 1'b0;
        next_lvl_q   = lvl_q;
        next_vec_q   = vec_q;
        // reset vector on reset cause or selected watchdog
        next_rst_req = next_cause_seen || (i_watchdog_overflow && !i_watchdog_to_nmi);
        // watchdog as NMI holds until acknowledged
        next_nmi     = (nmi && !i_cpu_ack) || (i_watchdog_overflow && i_watchdog_to_nmi);
        // follow the current winner; cleared flags drop out of the search
        if (win.req) begin
            next_req = 1'b1;
            // vector follows the winner whenever its level or vector differs from the held one
            if (!req || win.level != lvl_q || win.vector != vec_q) begin
                next_lvl_q = win.level;
                next_vec_q = win.vector;
            end
        end
        // Acknowledged request drops for one cycle so the flag clear can land
        if (req && i_cpu_ack) begin
            next_req = 1'b0;
        end
        // never issue a vector with no hardware source
        if (vip_pkg::VEC_FORBIDDEN[next_vec_q]) begin
            next_req = 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            req     <= 1'b0;
            lvl_q   <= '0;
            vec_q   <= '0;
            nmi     <= 1'b0;
            rst_req <= 1'b0;
        end else begin
            req     <= next_req;
            lvl_q   <= next_lvl_q;
            vec_q   <= next_vec_q;
            nmi     <= next_nmi;
            rst_req <= next_rst_req;
        end
    end

    assign o_cpu_req    = req;
    assign o_cpu_level  = lvl_q;
    assign o_cpu_nmi    = nmi;
    assign o_cpu_reset  = rst_req;
    assign o_cpu_vector = rst_req ? vip_pkg::VEC_RESET : (nmi ? vip_pkg::VEC_NMI : vec_q);
    assign o_table_base = {base_hi, {vip_pkg::BASE_ALIGN_BITS{1'b0}}};
    assign o_vector_address = o_table_base
                            + (vip_pkg::VEC_STRIDE * {19'h00000, o_cpu_vector});

endmodule // interrupt_priority_unit

// file: pkg/vip_pkg.sv
// Constants for the vectored interrupt priority unit
package vip_pkg;
    localparam int          VEC_W           = 5;
    localparam int          LVL_W           = 3;
    localparam int          NUM_VEC         = 32;
    localparam logic [2:0]  LVL_RESET       = 3'h0;
    localparam logic [23:0] TABLE_BASE_INIT = 24'h008000;
    localparam logic [23:0] VEC_STRIDE      = 24'h000004;
    localparam int          BASE_ALIGN_BITS = 8;
    localparam logic [4:0]  VEC_RESET       = 5'h00;
    localparam logic [4:0]  VEC_NMI         = 5'h02;
    localparam logic [4:0]  VEC_SUPPLY      = 5'h04;
    localparam logic [4:0]  VEC_PORT        = 5'h05;
    localparam logic [4:0]  VEC_CLOCK_GEN   = 5'h07;
    localparam logic [4:0]  VEC_TIMER0      = 5'h09;
    localparam logic [4:0]  VEC_SERIAL0     = 5'h0a;
    localparam logic [4:0]  VEC_TIMER1      = 5'h0b;
    localparam logic [4:0]  VEC_I2C0        = 5'h0d;
    // Vectors with no hardware source: 3 compiler, 6/8/21 reserved
    localparam logic [31:0] VEC_FORBIDDEN   = 32'h00200148;
    localparam int          SERIAL_CAUSES   = 7;
    localparam int          I2C_CAUSES      = 8;
    localparam int          NUM_SRC         = 7;
endpackage

// file: pkg/vip_req_if.sv
// Request, level and vector bundle between resolver and top
`timescale 1ns/1ns
interface vip_req_if;
    logic                           req;
    logic [vip_pkg::LVL_W-1:0]      level;
    logic [vip_pkg::VEC_W-1:0]      vector;
    modport src (output req, output level, output vector);
    modport dst (input req, input level, input vector);
endinterface

// file: hw/vip_cause_gate.sv
// Flag-and-enable gating of one peripheral's causes into one request
`timescale 1ns/1ns
module vip_cause_gate #(
    parameter int N = 1
) (
    // Causes
    input  wire logic [N-1:0] i_flag,
    input  wire logic [N-1:0] i_enable,
    // Request
    output logic              o_req
);
    if (N < 1) begin : g_bad_n
        $error("N must be at least 1");
    end
    // Level gating, so a late enable on a set flag still requests
    assign o_req = |(i_flag & i_enable);
endmodule // vip_cause_gate

// file: hw/vip_resolver.sv
// Level-then-vector priority search over the maskable sources
`timescale 1ns/1ns
module vip_resolver #(
    parameter int N = 7
) (
    // Sources
    input  wire logic [N-1:0]                    i_req,
    input  wire logic [N*vip_pkg::LVL_W-1:0]     i_level,
    input  wire logic [N*vip_pkg::VEC_W-1:0]     i_vector,
    // Winner
    vip_req_if.src                               win
);
    if (N < 1) begin : g_bad_n
        $error("N must be at least 1");
    end
    logic                       best_req;
    logic [vip_pkg::LVL_W-1:0]  best_lvl;
    logic [vip_pkg::VEC_W-1:0]  best_vec;
    always_comb begin
        logic [vip_pkg::LVL_W-1:0] l;
        logic [vip_pkg::VEC_W-1:0] v;
        l = '0;
        v = '0;
        best_req = 1'b0;
        best_lvl = '0;
        best_vec = '0;
        for (int i = 0; i < N; i++) begin
            l = i_level[i*vip_pkg::LVL_W +: vip_pkg::LVL_W];
            v = i_vector[i*vip_pkg::VEC_W +: vip_pkg::VEC_W];
            if (i_req[i] && l != vip_pkg::LVL_RESET) begin
                if (!best_req || l > best_lvl || (l == best_lvl && v < best_vec)) begin
                    best_req = 1'b1;
                    best_lvl = l;
                    best_vec = v;
                end
            end
        end
    end
    assign win.req    = best_req;
    assign win.level  = best_lvl;
    assign win.vector = best_vec;
endmodule // vip_resolver

// file: tb/cpu_model.sv
// CPU side model: takes requests after a chosen wait
`timescale 1ns/1ns
module cpu_model (
    // Control
    input  wire logic       i_clk,
    input  wire logic       i_enable,
    input  wire logic [7:0] i_delay,
    // Request
    input  wire logic       i_req,
    input  wire logic       i_nmi,
    input  wire logic [2:0] i_level,
    // Acceptance
    output logic            o_ack
);
    logic [7:0] count = 8'h00;
    initial o_ack = 1'b0;
    always @(posedge i_clk) begin
        o_ack <= 1'b0;
        count <= 8'h00;
        if (i_enable && !o_ack && (i_nmi || (i_req && i_level != 3'h0))) begin
            count <= count + 8'h01;
            o_ack <= (count == i_delay);
        end
    end
endmodule // cpu_model

// file: tb/interrupt_priority_unit_properties.sv
// Port checks for the interrupt priority unit
`timescale 1ns/1ns
module interrupt_priority_unit_properties (
    // Clock and reset
    input wire logic        i_clk,
    input wire logic        i_rst,
    // Inputs
    input wire logic        i_reset_cause,
    input wire logic        i_watchdog_overflow,
    input wire logic        i_watchdog_to_nmi,
    input wire logic [23:0] i_table_base_wdata,
    input wire logic        i_table_base_we,
    input wire logic        i_cpu_ack,
    // Outputs
    input wire logic        o_cpu_req,
    input wire logic        o_cpu_nmi,
    input wire logic        o_cpu_reset,
    input wire logic [2:0]  o_cpu_level,
    input wire logic [4:0]  o_cpu_vector,
    input wire logic [23:0] o_vector_address,
    input wire logic [23:0] o_table_base
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    sequence s_accept;
        o_cpu_req && i_cpu_ack;
    endsequence
    sequence s_pin_held;
        i_reset_cause ##1 i_reset_cause;
    endsequence
    sequence s_wdt_nmi;
        i_watchdog_overflow && i_watchdog_to_nmi && !i_reset_cause;
    endsequence
    a_ack_drops: assert property (s_accept |=> !o_cpu_req)
        else $error("request kept after ack");
    a_level_nonzero: assert property (o_cpu_req |-> o_cpu_level != 3'h0)
        else $error("level zero request");
    a_legal_vector: assert property (o_cpu_req && !o_cpu_nmi && !o_cpu_reset
        |-> o_cpu_vector inside {5'h04, 5'h05, 5'h07, 5'h09, 5'h0a, 5'h0b, 5'h0d})
        else $error("vector outside map");
    a_reset_vector: assert property (o_cpu_reset |-> o_cpu_vector == 5'h00)
        else $error("reset vector wrong");
    a_nmi_vector: assert property (o_cpu_nmi && !o_cpu_reset |-> o_cpu_vector == 5'h02)
        else $error("nmi vector wrong");
    a_nmi_route: assert property (s_wdt_nmi |=> o_cpu_nmi)
        else $error("overflow not sent to nmi");
    a_reset_route: assert property (i_watchdog_overflow
        && !i_watchdog_to_nmi |=> o_cpu_reset) else $error("reset cause lost");
    a_pin_reset: assert property (s_pin_held |-> ##3 o_cpu_reset)
        else $error("held reset cause lost");
    a_base_write: assert property (i_table_base_we
        |=> o_table_base == ($past(i_table_base_wdata) & 24'hffff00))
        else $error("base not written");
    a_vector_addr: assert property (o_vector_address
        == o_table_base + {17'h0, o_cpu_vector, 2'b00}) else $error("address wrong");
endmodule // interrupt_priority_unit_properties
bind interrupt_priority_unit interrupt_priority_unit_properties
    u_interrupt_priority_unit_properties (.*);

// file: tb/interrupt_priority_unit_test.sv
// Self-checking bench for the interrupt priority unit
`timescale 1ns/1ns
module interrupt_priority_unit_test;
    typedef struct packed {
        logic [6:0]  mask;
        logic [20:0] lvl;
        logic        req;
        logic [4:0]  vec;
        logic [2:0]  clvl;
    } row_type;
    // Mask bits are the sources of vectors 4,5,7,9,10,11,13
    row_type rows [8] = '{
        '{7'h7f, 21'h049249, 1'b1, 5'h04, 3'h1}, '{7'h7f, 21'h1c9249, 1'b1, 5'h0d, 3'h7},
        '{7'h7f, 21'h1ffff8, 1'b1, 5'h05, 3'h7}, '{7'h7f, 21'h049289, 1'b1, 5'h07, 3'h2},
        '{7'h7f, 21'h049a49, 1'b1, 5'h09, 3'h5}, '{7'h7f, 21'h04e249, 1'b1, 5'h0a, 3'h6},
        '{7'h7f, 21'h061249, 1'b1, 5'h0b, 3'h4}, '{7'h40, 21'h000000, 1'b0, 5'h00, 3'h0}};
    logic [20:0] one [3] = '{21'h000800, 21'h100000, 21'h000008};
    logic [4:0]  onev [3] = '{5'h0a, 5'h0d, 5'h07};
    logic        i_clk = 1'b0, i_rst = 1'b1, rc = 1'b0, wov = 1'b0, wnmi = 1'b0;
    logic        lwe = 1'b0, bwe = 1'b0, ack_en = 1'b0, ack;
    logic [7:0]  dly = 8'h03;
    logic [20:0] fl = 21'h0, en = 21'h0, lvl = 21'h0;
    logic [23:0] wdata = 24'h0, base = 24'h008000, addr, tbase;
    logic        req, nmi, rout;
    logic [2:0]  level;
    logic [4:0]  vec;
    int          errors = 0, total_checks = 0, cycles = 0;
    always #5 i_clk = ~i_clk;
    interrupt_priority_unit u_interrupt_priority_unit (.i_clk(i_clk), .i_rst(i_rst),
        .i_reset_cause(rc), .i_watchdog_overflow(wov), .i_watchdog_to_nmi(wnmi),
        .i_supply_flag(fl[0]), .i_supply_en(en[0]), .i_port_flag(fl[1]), .i_port_en(en[1]),
        .i_clock_gen_flag(fl[3:2]), .i_clock_gen_en(en[3:2]), .i_timer0_flag(fl[4]),
        .i_timer0_en(en[4]), .i_serial0_flag(fl[11:5]), .i_serial0_en(en[11:5]),
        .i_timer1_flag(fl[12]), .i_timer1_en(en[12]), .i_i2c0_flag(fl[20:13]),
        .i_i2c0_en(en[20:13]), .i_level(lvl), .i_level_we(lwe), .i_table_base_wdata(wdata),
        .i_table_base_we(bwe), .i_cpu_ack(ack), .o_cpu_req(req), .o_cpu_nmi(nmi),
        .o_cpu_reset(rout), .o_cpu_level(level), .o_cpu_vector(vec),
        .o_vector_address(addr), .o_table_base(tbase));
    cpu_model u_cpu_model (.i_clk(i_clk), .i_enable(ack_en), .i_delay(dly), .i_req(req),
        .i_nmi(nmi), .i_level(level), .o_ack(ack));
    task automatic print_verdict;
        $display("checks %0d, mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Generous ceiling: the sequence needs well under two hundred cycles
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            print_verdict();
        end
    end
    task automatic step(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s: expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic outs(input logic r, input logic [4:0] v, input logic [2:0] l);
        check("req", 24'(req), 24'(r));
        if (r === 1'b1) begin
            check("vector", 24'(vec), 24'(v));
            check("level", 24'(level), 24'(l));
            check("address", addr, base + {17'h0, v, 2'b00});
        end
    endtask
    task automatic levels(input logic [20:0] l);
        @(posedge i_clk);
        lvl <= l;
        lwe <= 1'b1;
        @(posedge i_clk);
        lwe <= 1'b0;
    endtask
    // Multi-cause sources get every cause bit; clock source uses one oscillator only
    task automatic drive(input logic [6:0] m);
        @(posedge i_clk);
        fl <= {{8{m[6]}}, m[5], {7{m[4]}}, m[3], 1'b0, m[2], m[1], m[0]};
        en <= {{8{m[6]}}, m[5], {7{m[4]}}, m[3], {2{m[2]}}, m[1], m[0]};
    endtask
    task automatic try(input logic [6:0] m, input logic r, input logic [4:0] v, logic [2:0] l);
        drive(m);
        step(1);
        outs(r, v, l);
    endtask
    initial begin
        repeat (16) @(posedge i_clk);
        i_rst <= 1'b0;
        try(7'h7f, 1'b0, 5'h00, 3'h0);
        check("base", tbase, 24'h008000);
        $display("reset test done");
        foreach (rows[k]) begin
            levels(rows[k].lvl);
            try(rows[k].mask, rows[k].req, rows[k].vec, rows[k].clvl);
            drive(7'h00);
        end
        $display("priority table done");
        levels(21'h000600);
        dly <= 8'h03;
        ack_en <= 1'b1;
        try(7'h08, 1'b1, 5'h09, 3'h3);
        for (int t = 0; t < 20 && ack !== 1'b1; t++)
            step(1);
        step(1);
        outs(1'b0, 5'h00, 3'h0);
        step(1);
        outs(1'b1, 5'h09, 3'h3);
        drive(7'h00);
        ack_en <= 1'b0;
        levels(21'h010005);
        try(7'h20, 1'b1, 5'h0b, 3'h2);
        try(7'h21, 1'b1, 5'h04, 3'h5);
        try(7'h20, 1'b1, 5'h0b, 3'h2);
        try(7'h00, 1'b0, 5'h00, 3'h0);
        $display("accept and replace done");
        levels(21'h049249);
        foreach (one[k]) begin
            @(posedge i_clk);
            fl <= one[k];
            step(2);
            outs(1'b0, 5'h00, 3'h0);
            @(posedge i_clk);
            en <= 21'h1fffff;
            step(1);
            outs(1'b1, onev[k], 3'h1);
            @(posedge i_clk);
            fl <= 21'h0;
            en <= 21'h0;
        end
        @(posedge i_clk);
        wdata <= 24'h123456;
        bwe <= 1'b1;
        @(posedge i_clk);
        bwe <= 1'b0;
        base = 24'h123400;
        try(7'h02, 1'b1, 5'h05, 3'h1);
        check("base", tbase, base);
        $display("shared causes and base done");
        @(posedge i_clk);
        ack_en <= 1'b1;
        dly <= 8'h00;
        wov <= 1'b1;
        wnmi <= 1'b1;
        @(posedge i_clk);
        wov <= 1'b0;
        #1;
        check("nmi", 24'(nmi), 24'h1);
        check("vector", 24'(vec), 24'h2);
        step(3);
        @(posedge i_clk);
        wov <= 1'b1;
        wnmi <= 1'b0;
        @(posedge i_clk);
        wov <= 1'b0;
        rc <= 1'b1;
        #1;
        check("reset", 24'(rout), 24'h1);
        check("vector", 24'(vec), 24'h0);
        @(posedge i_clk);
        rc <= 1'b0;
        step(4);
        check("reset", 24'(rout), 24'h0);
        @(posedge i_clk);
        rc <= 1'b1;
        step(5);
        check("reset", 24'(rout), 24'h1);
        check("vector", 24'(vec), 24'h0);
        @(posedge i_clk);
        rc <= 1'b0;
        i_rst <= 1'b1;
        drive(7'h00);
        @(posedge i_clk);
        i_rst <= 1'b0;
        step(1);
        check("reset", 24'(rout), 24'h0);
        check("base", tbase, 24'h008000);
        $display("watchdog and second reset done");
        print_verdict();
    end
endmodule // interrupt_priority_unit_test
